// ### design/stf_cfg.svh
// Constants for the status rising-edge filter block.
// Assumes nothing; definitions only.
`ifndef STF_CFG_SVH
`define STF_CFG_SVH

`define STF_WIDTH       16
`define STF_NUM_SETS    5

// Implemented bits per register set
`define STF_MEAS_MASK   16'h0BBF
`define STF_QUES_MASK   16'h4110
`define STF_OPER_MASK   16'h0663
`define STF_TRIG_MASK   16'h0002
`define STF_ARM_MASK    16'h0002

// Reset values
`define STF_FALL_RESET  16'h0000
`define STF_ENAB_RESET  16'h0000
`define STF_EVENT_RESET 16'h0000

// Measurement bit positions
`define STF_MEAS_OVERRANGE  0
`define STF_MEAS_LOW_ONE    1
`define STF_MEAS_HIGH_ONE   2
`define STF_MEAS_LOW_TWO    3
`define STF_MEAS_HIGH_TWO   4
`define STF_MEAS_READY      5
`define STF_MEAS_HAS_DATA   7
`define STF_MEAS_HALF       8
`define STF_MEAS_FULL       9
`define STF_MEAS_PRETRIG    11

// Questionable bit positions
`define STF_QUES_TEMP       4
`define STF_QUES_CAL        8
`define STF_QUES_WARN       14

// Operation bit positions
`define STF_OPER_CAL        0
`define STF_OPER_SETTLE     1
`define STF_OPER_TRIG       5
`define STF_OPER_ARM        6
`define STF_OPER_CALC       9
`define STF_OPER_IDLE       10

// Trigger and arm bit position
`define STF_LAYER_CHAIN_ONE 1

// Synchroniser depth
`define STF_SYNC_STAGES     2

`endif

// ### design/stf_pkg.sv
// Types for the status rising-edge filter block.
// Assumes stf_cfg.svh is on the include path.
`include "stf_cfg.svh"

package stf_pkg;

  typedef enum logic [1:0] {
    STF_OP_WRITE  = 2'h0,
    STF_OP_QUERY  = 2'h1,
    STF_OP_PRESET = 2'h3,
    STF_OP_CLEAR  = 2'h2
  } stf_op_t;

  typedef enum logic [2:0] {
    STF_SET_MEAS = 3'h0,
    STF_SET_QUES = 3'h1,
    STF_SET_OPER = 3'h2,
    STF_SET_TRIG = 3'h3,
    STF_SET_ARM  = 3'h4
  } stf_set_t;

  typedef enum logic [1:0] {
    STF_REG_RISE  = 2'h0,
    STF_REG_FALL  = 2'h1,
    STF_REG_ENAB  = 2'h2,
    STF_REG_EVENT = 2'h3
  } stf_reg_t;

endpackage

// ### design/stf_sync.sv
// Two-stage synchroniser for a vector of pin-level condition inputs.
// Assumes inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none

module stf_sync
  import stf_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_resetn,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      meta   <= '0;
      o_sync <= '0;
    end else if (i_ce) begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

`default_nettype wire

// ### design/stf_edge_set.sv
// One register set: rise and fall filters, enable mask, event latch.
// Assumes conditions arrive already synchronised to i_clk_sys.
`timescale 1ns/10ps
`default_nettype none

module stf_edge_set
  import stf_pkg::*;
#(
  parameter int              W    = 16,
  parameter logic [W-1:0]    IMPL = '1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_resetn,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_cond,
  input  wire logic         i_wr_rise,
  input  wire logic         i_wr_fall,
  input  wire logic         i_wr_enab,
  input  wire logic [W-1:0] i_wdata,
  input  wire logic         i_preset,
  input  wire logic         i_ev_clr,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall,
  output logic      [W-1:0] o_enab,
  output logic      [W-1:0] o_event,
  output logic              o_summary
);

  logic [W-1:0] prev;
  wire  [W-1:0] rise_hit   = i_cond & ~prev & o_rise;
  wire  [W-1:0] fall_hit   = ~i_cond & prev & o_fall;
  wire  [W-1:0] wr_val     = i_wdata & IMPL;
  wire  [W-1:0] next_event = (o_event & ~{W{i_ev_clr}}) | rise_hit | fall_hit;

  assign o_summary = |(o_event & o_enab);

  // One previous sample per bit, so one change latches once
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      prev    <= '0;
      o_event <= `STF_EVENT_RESET;
    end else if (i_ce) begin
      prev    <= i_cond;
      o_event <= next_event;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rise <= IMPL;
      o_fall <= `STF_FALL_RESET;
      o_enab <= `STF_ENAB_RESET;
    end else if (i_ce) begin
      if (i_preset) begin
        o_rise <= IMPL;
        o_fall <= `STF_FALL_RESET;
        o_enab <= `STF_ENAB_RESET;
      end else begin
        if (i_wr_rise) o_rise <= wr_val;
        if (i_wr_fall) o_fall <= wr_val;
        if (i_wr_enab) o_enab <= wr_val;
      end
    end
  end

endmodule

`default_nettype wire

// ### design/stf_top.sv
// Status rising-edge filter: five register sets behind a decoded command port.
// Assumes the host command parser hands over one decoded command per cycle,
// its numeric parameter already in binary; condition inputs are async pins.
//
// Behaviour
// - Filter write loads bits from binary form of parameter; zero clears all.
// - Power-up sets every implemented rising-edge filter bit to one.
// - Preset sets rising filters to one again; clear-status leaves them alone.
// - Filter query returns a value whose set bits are the set filter bits.
// - Condition rising with filter bit set latches the matching event bit.
// - Filter bit one enables rising detection; zero blocks that event.
// - Measurement B0 over-range, B1..B4 limit one and two low/high crossings.
// - Measurement B5 rises when a reading is taken and processed.
// - Measurement B7 rises when trace buffer holds at least two readings.
// - Measurement B8 buffer half full, B9 buffer full.
// - Measurement B11 pretrigger; B6, B10, B12..B15 carry no event.
// - Questionable B4 junction invalid, B8 calibration invalid, B14 ignored.
// - Operation B0 calibration start, B1 settling start.
// - Operation B5 waiting in trigger layer, B6 waiting in arm layer.
// - Operation B9 math calculation start, B10 entering idle.
// - Trigger B1 set while operation waits in trigger layer.
// - Arm B1 set while in an arm layer; other arm bits unused.
// - Masked event never drives summary; unmasked latched event does.
// - Condition falling with fall filter bit set latches event bit.
`timescale 1ns/10ps
`default_nettype none

module stf_top
  import stf_pkg::*;
#(
  parameter int W = `STF_WIDTH
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_resetn,
  input  wire logic         i_ce,
  // Decoded command port
  input  wire logic         i_cmd_valid,
  input  wire stf_op_t      i_cmd_op,
  input  wire stf_set_t     i_cmd_set,
  input  wire stf_reg_t     i_cmd_reg,
  input  wire logic [W-1:0] i_cmd_value,
  output logic              o_rsp_valid,
  output logic      [W-1:0] o_rsp_value,
  // Measurement conditions
  input  wire logic         i_reading_overrange,
  input  wire logic         i_lower_bound_one_crossed,
  input  wire logic         i_upper_bound_one_crossed,
  input  wire logic         i_lower_bound_two_crossed,
  input  wire logic         i_upper_bound_two_crossed,
  input  wire logic         i_reading_ready,
  input  wire logic         i_buffer_has_data,
  input  wire logic         i_buffer_half_level,
  input  wire logic         i_buffer_full_flag,
  input  wire logic         i_buffer_pretrigger_done,
  // Questionable conditions
  input  wire logic         i_junction_invalid,
  input  wire logic         i_cal_constant_invalid,
  input  wire logic         i_command_param_ignored,
  // Operation conditions
  input  wire logic         i_calibrating,
  input  wire logic         i_settling,
  input  wire logic         i_waiting_trigger,
  input  wire logic         i_waiting_arm,
  input  wire logic         i_calculating,
  input  wire logic         i_idle,
  // Per-set summaries
  output logic              o_meas_summary,
  output logic              o_ques_summary,
  output logic              o_oper_summary,
  output logic              o_trig_summary,
  output logic              o_arm_summary
);

  localparam int NS = `STF_NUM_SETS;

  function automatic logic [W-1:0] impl_mask(input int idx);
    case (idx)
      0:       impl_mask = `STF_MEAS_MASK;
      1:       impl_mask = `STF_QUES_MASK;
      2:       impl_mask = `STF_OPER_MASK;
      3:       impl_mask = `STF_TRIG_MASK;
      default: impl_mask = `STF_ARM_MASK;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Condition assembly

  logic [W-1:0] meas_raw;
  logic [W-1:0] ques_raw;
  logic [W-1:0] oper_raw;
  logic [W-1:0] trig_raw;
  logic [W-1:0] arm_raw;

  always_comb begin
    meas_raw = '0;
    meas_raw[`STF_MEAS_OVERRANGE] = i_reading_overrange;
    meas_raw[`STF_MEAS_LOW_ONE]   = i_lower_bound_one_crossed;
    meas_raw[`STF_MEAS_HIGH_ONE]  = i_upper_bound_one_crossed;
    meas_raw[`STF_MEAS_LOW_TWO]   = i_lower_bound_two_crossed;
    meas_raw[`STF_MEAS_HIGH_TWO]  = i_upper_bound_two_crossed;
    meas_raw[`STF_MEAS_READY]     = i_reading_ready;
    meas_raw[`STF_MEAS_HAS_DATA]  = i_buffer_has_data;
    meas_raw[`STF_MEAS_HALF]      = i_buffer_half_level;
    meas_raw[`STF_MEAS_FULL]      = i_buffer_full_flag;
    meas_raw[`STF_MEAS_PRETRIG]   = i_buffer_pretrigger_done;
  end

  always_comb begin
    ques_raw = '0;
    ques_raw[`STF_QUES_TEMP] = i_junction_invalid;
    ques_raw[`STF_QUES_CAL]  = i_cal_constant_invalid;
    ques_raw[`STF_QUES_WARN] = i_command_param_ignored;
  end

  always_comb begin
    oper_raw = '0;
    oper_raw[`STF_OPER_CAL]    = i_calibrating;
    oper_raw[`STF_OPER_SETTLE] = i_settling;
    oper_raw[`STF_OPER_TRIG]   = i_waiting_trigger;
    oper_raw[`STF_OPER_ARM]    = i_waiting_arm;
    oper_raw[`STF_OPER_CALC]   = i_calculating;
    oper_raw[`STF_OPER_IDLE]   = i_idle;
  end

  always_comb begin
    trig_raw = '0;
    arm_raw  = '0;
    trig_raw[`STF_LAYER_CHAIN_ONE] = i_waiting_trigger;
    arm_raw[`STF_LAYER_CHAIN_ONE]  = i_waiting_arm;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: all condition pins cross in one vector

  logic [NS*W-1:0] cond_sync;

  stf_sync #(
    .W (NS*W)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_ce      (i_ce),
    .i_async   ({arm_raw, trig_raw, oper_raw, ques_raw, meas_raw}),
    .o_sync    (cond_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire cmd_write  = i_cmd_valid && (i_cmd_op == STF_OP_WRITE);
  wire cmd_query  = i_cmd_valid && (i_cmd_op == STF_OP_QUERY);
  wire cmd_preset = i_cmd_valid && (i_cmd_op == STF_OP_PRESET);
  wire cmd_clear  = i_cmd_valid && (i_cmd_op == STF_OP_CLEAR);

  wire wr_rise  = cmd_write && (i_cmd_reg == STF_REG_RISE);
  wire wr_fall  = cmd_write && (i_cmd_reg == STF_REG_FALL);
  wire wr_enab  = cmd_write && (i_cmd_reg == STF_REG_ENAB);
  wire rd_event = cmd_query && (i_cmd_reg == STF_REG_EVENT);

  logic [W-1:0] rise_q  [NS];
  logic [W-1:0] fall_q  [NS];
  logic [W-1:0] enab_q  [NS];
  logic [W-1:0] event_q [NS];
  logic [NS-1:0] summary;

  // Preset leaves events alone; clear-status only clears events
  for (genvar g = 0; g < NS; g++) begin : g_set
    wire sel = (i_cmd_set == stf_set_t'(g));

    stf_edge_set #(
      .W    (W),
      .IMPL (impl_mask(g))
    ) u_set (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .i_ce      (i_ce),
      .i_cond    (cond_sync[g*W +: W]),
      .i_wr_rise (wr_rise && sel),
      .i_wr_fall (wr_fall && sel),
      .i_wr_enab (wr_enab && sel),
      .i_wdata   (i_cmd_value),
      .i_preset  (cmd_preset),
      .i_ev_clr  (cmd_clear || (rd_event && sel)),
      .o_rise    (rise_q[g]),
      .o_fall    (fall_q[g]),
      .o_enab    (enab_q[g]),
      .o_event   (event_q[g]),
      .o_summary (summary[g])
    );
  end

  assign o_meas_summary = summary[STF_SET_MEAS];
  assign o_ques_summary = summary[STF_SET_QUES];
  assign o_oper_summary = summary[STF_SET_OPER];
  assign o_trig_summary = summary[STF_SET_TRIG];
  assign o_arm_summary  = summary[STF_SET_ARM];

  ////////////////////////////////////////////////////////////////////////////
  // Query response: event value is taken before its clear lands

  logic [W-1:0] next_rsp_value;

  always_comb begin
    case (i_cmd_reg)
      STF_REG_RISE:  next_rsp_value = rise_q[i_cmd_set];
      STF_REG_FALL:  next_rsp_value = fall_q[i_cmd_set];
      STF_REG_ENAB:  next_rsp_value = enab_q[i_cmd_set];
      STF_REG_EVENT: next_rsp_value = event_q[i_cmd_set];
      default:       next_rsp_value = '0;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rsp_valid <= 1'b0;
      o_rsp_value <= '0;
    end else if (i_ce) begin
      o_rsp_valid <= cmd_query;
      if (cmd_query) o_rsp_value <= next_rsp_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic started;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) started <= 1'b0;
    else if (i_ce) started <= 1'b1;
  end

  wire [W-1:0] mc = cond_sync[W-1:0];

  sequence s_meas_rise_write;
    i_ce && wr_rise && (i_cmd_set == STF_SET_MEAS);
  endsequence

  property p_rise_write;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      s_meas_rise_write |=> rise_q[0] == ($past(i_cmd_value) & `STF_MEAS_MASK);
  endproperty
  a_rise_write: assert property (p_rise_write) else $error("rise filter write wrong");

  property p_rise_reset;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      !started |-> (rise_q[0] == `STF_MEAS_MASK) && (rise_q[2] == `STF_OPER_MASK);
  endproperty
  a_rise_reset: assert property (p_rise_reset) else $error("rise filter reset wrong");

  property p_preset;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && cmd_preset |=> (rise_q[1] == `STF_QUES_MASK) && (fall_q[0] == '0) && (enab_q[0] == '0);
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not restore filters");

  property p_clear_keeps;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && cmd_clear |=> $stable(rise_q[0]) && $stable(fall_q[0]) && $stable(rise_q[2]);
  endproperty
  a_clear_keeps: assert property (p_clear_keeps) else $error("clear altered rise filter");

  sequence s_meas_rise_query;
    i_ce && cmd_query && (i_cmd_reg == STF_REG_RISE) && (i_cmd_set == STF_SET_MEAS);
  endsequence

  property p_query;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      s_meas_rise_query |=> o_rsp_valid && (o_rsp_value == $past(rise_q[0]));
  endproperty
  a_query: assert property (p_query) else $error("query returned wrong value");

  property p_rise_latch;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && $past(i_ce) && $rose(mc[`STF_MEAS_READY]) && rise_q[0][`STF_MEAS_READY]
      |=> event_q[0][`STF_MEAS_READY];
  endproperty
  a_rise_latch: assert property (p_rise_latch) else $error("enabled rise not latched");

  property p_rise_blocked;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && $past(i_ce) && $rose(mc[`STF_MEAS_HALF]) && !rise_q[0][`STF_MEAS_HALF] &&
      !event_q[0][`STF_MEAS_HALF] |=> !event_q[0][`STF_MEAS_HALF];
  endproperty
  a_rise_blocked: assert property (p_rise_blocked) else $error("masked rise latched");

  property p_fall_latch;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && $past(i_ce) && $fell(mc[`STF_MEAS_OVERRANGE]) && fall_q[0][`STF_MEAS_OVERRANGE]
      |=> event_q[0][`STF_MEAS_OVERRANGE];
  endproperty
  a_fall_latch: assert property (p_fall_latch) else $error("enabled fall not latched");

  property p_summary;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && $rose(event_q[2][`STF_OPER_IDLE]) && enab_q[2][`STF_OPER_IDLE] |-> o_oper_summary ##1
      (o_oper_summary || !enab_q[2][`STF_OPER_IDLE] || !event_q[2][`STF_OPER_IDLE]);
  endproperty
  a_summary: assert property (p_summary) else $error("summary not raised");

endmodule

`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the status rising-edge filter top level.
// Assumes stf_cfg.svh and stf_pkg are compiled first; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
`include "stf_cfg.svh"

module tb_top
  import stf_pkg::*;
;

  typedef struct {
    stf_set_t    st;
    logic [15:0] wv;
    logic [15:0] ev;
  } stf_row_t;

  logic        i_clk_sys;
  logic        i_resetn;
  logic        i_ce;
  logic        i_cmd_valid;
  stf_op_t     i_cmd_op;
  stf_set_t    i_cmd_set;
  stf_reg_t    i_cmd_reg;
  logic [15:0] i_cmd_value;
  logic        o_rsp_valid;
  logic [15:0] o_rsp_value;
  logic [18:0] pins;
  logic [4:0]  summ;
  int          bad_count;
  int          n_tests;
  int          k;

  ////////////////////////////////////////////////////////////////////////////
  // Tables
  stf_set_t    sets  [5]  = '{STF_SET_MEAS, STF_SET_QUES, STF_SET_OPER, STF_SET_TRIG, STF_SET_ARM};
  logic [15:0] masks [5]  = '{`STF_MEAS_MASK, `STF_QUES_MASK, `STF_OPER_MASK, `STF_TRIG_MASK, `STF_ARM_MASK};
  stf_set_t    pset  [19] = '{STF_SET_MEAS, STF_SET_MEAS, STF_SET_MEAS, STF_SET_MEAS, STF_SET_MEAS,
                              STF_SET_MEAS, STF_SET_MEAS, STF_SET_MEAS, STF_SET_MEAS, STF_SET_MEAS,
                              STF_SET_QUES, STF_SET_QUES, STF_SET_QUES, STF_SET_OPER, STF_SET_OPER,
                              STF_SET_OPER, STF_SET_OPER, STF_SET_OPER, STF_SET_OPER};
  int          pbit  [19] = '{0, 1, 2, 3, 4, 5, 7, 8, 9, 11, 4, 8, 14, 0, 1, 5, 6, 9, 10};
  // Out-of-mask bits must read back zero, so some rows write more than they expect
  stf_row_t    rows  [9]  = '{'{STF_SET_MEAS, 16'h0220, 16'h0220}, '{STF_SET_MEAS, 16'hFFFF, 16'h0BBF},
                              '{STF_SET_MEAS, 16'h0000, 16'h0000}, '{STF_SET_QUES, 16'h4110, 16'h4110},
                              '{STF_SET_QUES, 16'h0001, 16'h0000}, '{STF_SET_OPER, 16'h0402, 16'h0402},
                              '{STF_SET_OPER, 16'h0202, 16'h0202}, '{STF_SET_TRIG, 16'hFFFF, 16'h0002},
                              '{STF_SET_ARM,  16'h0001, 16'h0000}};

  stf_top i_dut (
    .i_clk_sys                 (i_clk_sys),
    .i_resetn                  (i_resetn),
    .i_ce                      (i_ce),
    .i_cmd_valid               (i_cmd_valid),
    .i_cmd_op                  (i_cmd_op),
    .i_cmd_set                 (i_cmd_set),
    .i_cmd_reg                 (i_cmd_reg),
    .i_cmd_value               (i_cmd_value),
    .o_rsp_valid               (o_rsp_valid),
    .o_rsp_value               (o_rsp_value),
    .i_reading_overrange       (pins[0]),
    .i_lower_bound_one_crossed (pins[1]),
    .i_upper_bound_one_crossed (pins[2]),
    .i_lower_bound_two_crossed (pins[3]),
    .i_upper_bound_two_crossed (pins[4]),
    .i_reading_ready           (pins[5]),
    .i_buffer_has_data         (pins[6]),
    .i_buffer_half_level       (pins[7]),
    .i_buffer_full_flag        (pins[8]),
    .i_buffer_pretrigger_done  (pins[9]),
    .i_junction_invalid        (pins[10]),
    .i_cal_constant_invalid    (pins[11]),
    .i_command_param_ignored   (pins[12]),
    .i_calibrating             (pins[13]),
    .i_settling                (pins[14]),
    .i_waiting_trigger         (pins[15]),
    .i_waiting_arm             (pins[16]),
    .i_calculating             (pins[17]),
    .i_idle                    (pins[18]),
    .o_meas_summary            (summ[0]),
    .o_ques_summary            (summ[1]),
    .o_oper_summary            (summ[2]),
    .o_trig_summary            (summ[3]),
    .o_arm_summary             (summ[4])
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // Strobe is dropped one edge later, so back-to-back calls leave a gap cycle
  task automatic send(input stf_op_t op, input stf_set_t st, input stf_reg_t rg, input logic [15:0] v);
    @(posedge i_clk_sys);
    i_cmd_valid <= 1'b1;
    i_cmd_op    <= op;
    i_cmd_set   <= st;
    i_cmd_reg   <= rg;
    i_cmd_value <= v;
    @(posedge i_clk_sys);
    i_cmd_valid <= 1'b0;
  endtask

  task automatic query(input stf_set_t st, input stf_reg_t rg, input logic [15:0] exp, input string what);
    send(STF_OP_QUERY, st, rg, 16'h0000);
    #1;
    chk({what, " valid"}, 16'h0001, {15'h0000, o_rsp_valid});
    chk(what, exp, o_rsp_value);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Sequence
  initial begin
    bad_count   = 0;
    n_tests     = 0;
    i_resetn    = 1'b0;
    i_ce        = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd_op    = STF_OP_WRITE;
    i_cmd_set   = STF_SET_MEAS;
    i_cmd_reg   = STF_REG_RISE;
    i_cmd_value = 16'h0000;
    pins        = 19'h00000;
    wait_cyc(20);
    i_resetn <= 1'b1;
    foreach (rows[r]) begin
      send(STF_OP_WRITE, rows[r].st, STF_REG_RISE, rows[r].wv);
      query(rows[r].st, STF_REG_RISE, rows[r].ev, "rise readback");
    end
    // Mid-run reset must restore every filter and enable default
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    wait_cyc(20);
    i_resetn <= 1'b1;
    for (k = 0; k < 5; k++) begin
      query(sets[k], STF_REG_RISE, masks[k], "rise after reset");
      query(sets[k], STF_REG_FALL, 16'h0000, "fall after reset");
      query(sets[k], STF_REG_ENAB, 16'h0000, "enable after reset");
      send(STF_OP_WRITE, sets[k], STF_REG_ENAB, 16'hFFFF);
    end
    // One condition at a time, each raised then lowered
    for (k = 0; k < 19; k++) begin
      @(posedge i_clk_sys);
      pins[k] <= 1'b1;
      wait_cyc(5);
      #1;
      chk("summary on event", 16'h0001, {15'h0000, summ[pset[k]]});
      query(pset[k], STF_REG_EVENT, 16'h0001 << pbit[k], "event on rise");
      query(pset[k], STF_REG_EVENT, 16'h0000, "event latched once");
      if (k == 15) begin
        chk("trigger summary", 16'h0001, {15'h0000, summ[3]});
        query(STF_SET_TRIG, STF_REG_EVENT, 16'h0002, "trigger chain event");
      end
      if (k == 16) begin
        chk("arm summary", 16'h0001, {15'h0000, summ[4]});
        query(STF_SET_ARM, STF_REG_EVENT, 16'h0002, "arm chain event");
      end
      @(posedge i_clk_sys);
      pins[k] <= 1'b0;
      wait_cyc(5);
      query(pset[k], STF_REG_EVENT, 16'h0000, "no event on fall");
    end
    // Partial filter, masking and falling edge on the measurement set
    send(STF_OP_WRITE, STF_SET_MEAS, STF_REG_ENAB, 16'h0000);
    send(STF_OP_WRITE, STF_SET_MEAS, STF_REG_RISE, 16'h0220);
    send(STF_OP_WRITE, STF_SET_MEAS, STF_REG_FALL, 16'h0001);
    @(posedge i_clk_sys);
    pins[9:0] <= 10'h3FF;
    wait_cyc(5);
    #1;
    chk("summary while masked", 16'h0000, {15'h0000, summ[0]});
    send(STF_OP_WRITE, STF_SET_MEAS, STF_REG_ENAB, 16'h0020);
    wait_cyc(1);
    #1;
    chk("summary when unmasked", 16'h0001, {15'h0000, summ[0]});
    query(STF_SET_MEAS, STF_REG_EVENT, 16'h0220, "filtered events");
    wait_cyc(1);
    #1;
    chk("summary after event clear", 16'h0000, {15'h0000, summ[0]});
    @(posedge i_clk_sys);
    pins[9:0] <= 10'h000;
    wait_cyc(5);
    query(STF_SET_MEAS, STF_REG_EVENT, 16'h0001, "fall filtered event");
    // Preset restores filters; clear-status leaves them alone
    send(STF_OP_WRITE, STF_SET_OPER, STF_REG_RISE, 16'h0000);
    send(STF_OP_PRESET, STF_SET_MEAS, STF_REG_RISE, 16'h0000);
    wait_cyc(1);
    for (k = 0; k < 5; k++) begin
      query(sets[k], STF_REG_RISE, masks[k], "rise after preset");
    end
    query(STF_SET_MEAS, STF_REG_FALL, 16'h0000, "fall after preset");
    query(STF_SET_MEAS, STF_REG_ENAB, 16'h0000, "enable after preset");
    send(STF_OP_WRITE, STF_SET_MEAS, STF_REG_RISE, 16'h0001);
    @(posedge i_clk_sys);
    pins[0] <= 1'b1;
    wait_cyc(5);
    send(STF_OP_CLEAR, STF_SET_MEAS, STF_REG_RISE, 16'h0000);
    wait_cyc(1);
    query(STF_SET_MEAS, STF_REG_RISE, 16'h0001, "rise kept by clear");
    query(STF_SET_MEAS, STF_REG_EVENT, 16'h0000, "event gone after clear");
    // Frozen clock enable must drop the command
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    send(STF_OP_WRITE, STF_SET_MEAS, STF_REG_RISE, 16'h0000);
    i_ce <= 1'b1;
    query(STF_SET_MEAS, STF_REG_RISE, 16'h0001, "write lost while frozen");
    report_and_stop();
  end

  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    wait_cyc(20000);
    bad_count++;
    $display("FAIL watchdog expected done seen timeout");
    report_and_stop();
  end

endmodule

`default_nettype wire
